// ### src/timed_pattern_unit.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module timed_pattern_unit (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire pattern_pkg::apb_req_t apb_i,
  output      pattern_pkg::apb_rsp_t apb_o,
  input  wire logic [3:0]           cmp_match_i,
  output      logic [15:0]          pattern_out_pins_o,
  output      logic [31:0]          pin_function_o,
  output      logic [7:0]           pattern_mode_o
);
  import pattern_pkg::*;

  regs_t        regs_reg;
  regs_t        regs_next;
  logic [31:0]  prdata_reg;
  logic [31:0]  prdata_next;
  logic [29:0]  idx;
  logic [8:0]   ofs;
  logic [8:0]   ofs_odd;
  logic         hit;
  logic         setup;
  logic         access;
  logic         wr_take;
  logic [GROUPS-1:0] fire;
  logic [PINS-1:0]   copy_mask;
  logic [PINS-1:0]   enables;
  logic [PINS-1:0]   staged;
  logic [31:0]  rd_word;

  function automatic logic same_lo(input regs_t r);
    return r.trig[2*SEL_W-1:SEL_W] == r.trig[SEL_W-1:0];
  endfunction : same_lo

  function automatic logic same_hi(input regs_t r);
    return r.trig[4*SEL_W-1:3*SEL_W] == r.trig[3*SEL_W-1:2*SEL_W];
  endfunction : same_hi

  function automatic logic [8:0] odd_of(input logic [27:0] k);
    return {k[OFS_HI:1], 1'b1};
  endfunction : odd_of

  // Halfword registers answer at their even index and at the odd byte above it.
  function automatic logic mapped(input logic [8:0] o);
    return (o[OFS_HI:1] == IDX_LATCH[OFS_HI:1]) || (o[OFS_HI:1] == IDX_FUNC_HI[OFS_HI:1]) ||
           (o[OFS_HI:1] == IDX_FUNC_LO[OFS_HI:1]) || (o[OFS_HI:3] == IDX_MODE[OFS_HI:3]);
  endfunction : mapped

  function automatic logic [7:0] get_byte(input regs_t r, input logic [8:0] o);
    logic [7:0] b;
    b = RST_BYTE;
    case (o)
      IDX_LATCH[OFS_HI:0]:        b = r.latch[15:8];
      odd_of(IDX_LATCH):          b = r.latch[7:0];
      IDX_FUNC_HI[OFS_HI:0]:      b = r.func_hi[15:8];
      odd_of(IDX_FUNC_HI):        b = r.func_hi[7:0];
      IDX_FUNC_LO[OFS_HI:0]:      b = r.func_lo[15:8];
      odd_of(IDX_FUNC_LO):        b = r.func_lo[7:0];
      IDX_MODE[OFS_HI:0]:         b = r.mode;
      IDX_TRIG[OFS_HI:0]:         b = r.trig;
      IDX_EN_HI[OFS_HI:0]:        b = r.en_hi;
      IDX_EN_LO[OFS_HI:0]:        b = r.en_lo;
      IDX_STG_HI[OFS_HI:0]:       b = same_hi(r) ? r.stg_hi : {r.stg_hi[7:4], RSVD_NIB};
      IDX_STG_HI_ALT[OFS_HI:0]:   b = same_hi(r) ? RSVD_BYTE : {RSVD_NIB, r.stg_hi[3:0]};
      IDX_STG_LO[OFS_HI:0]:       b = same_lo(r) ? r.stg_lo : {r.stg_lo[7:4], RSVD_NIB};
      IDX_STG_LO_ALT[OFS_HI:0]:   b = same_lo(r) ? RSVD_BYTE : {RSVD_NIB, r.stg_lo[3:0]};
      default:                    b = RST_BYTE;
    endcase
    return b;
  endfunction : get_byte

  function automatic regs_t put_byte(input regs_t r, input logic [8:0] o, input logic [7:0] d);
    regs_t n;
    n = r;
    case (o)
      IDX_LATCH[OFS_HI:0]:        n.latch[15:8] = (r.latch[15:8] & r.en_hi) | (d & ~r.en_hi);
      odd_of(IDX_LATCH):          n.latch[7:0]  = (r.latch[7:0] & r.en_lo) | (d & ~r.en_lo);
      IDX_FUNC_HI[OFS_HI:0]:      n.func_hi[15:8] = d;
      odd_of(IDX_FUNC_HI):        n.func_hi[7:0]  = d;
      IDX_FUNC_LO[OFS_HI:0]:      n.func_lo[15:8] = d;
      odd_of(IDX_FUNC_LO):        n.func_lo[7:0]  = d;
      IDX_MODE[OFS_HI:0]:         n.mode = d;
      IDX_TRIG[OFS_HI:0]:         n.trig = d;
      IDX_EN_HI[OFS_HI:0]:        n.en_hi = d;
      IDX_EN_LO[OFS_HI:0]:        n.en_lo = d;
      IDX_STG_HI[OFS_HI:0]: begin
        if (same_hi(r)) begin
          n.stg_hi = d;
        end else begin
          n.stg_hi[7:4] = d[7:4];
        end
      end
      IDX_STG_HI_ALT[OFS_HI:0]: begin
        if (!same_hi(r)) begin
          n.stg_hi[3:0] = d[3:0];
        end
      end
      IDX_STG_LO[OFS_HI:0]: begin
        if (same_lo(r)) begin
          n.stg_lo = d;
        end else begin
          n.stg_lo[7:4] = d[7:4];
        end
      end
      IDX_STG_LO_ALT[OFS_HI:0]: begin
        // Shared trigger leaves this byte reserved, so the write is dropped.
        if (!same_lo(r)) begin
          n.stg_lo[3:0] = d[3:0];
        end
      end
      default: n = r;
    endcase
    return n;
  endfunction : put_byte

  // Index bits 23-9 (address bits 25-11) take no part in the decode, so the block aliases through that range.
  assign idx     = apb_i.paddr[31:WORD_LSB];
  assign ofs     = idx[OFS_HI:0];
  assign ofs_odd = {ofs[OFS_HI:1], 1'b1};
  assign hit     = (apb_i.paddr[WORD_LSB-1:0] == 2'b00) &&
                   (idx[AREA_HI:AREA_LO] == IDX_LATCH[AREA_HI:AREA_LO]) && mapped(ofs);
  assign setup   = apb_i.psel & ~apb_i.penable;
  assign access  = apb_i.psel & apb_i.penable;
  assign wr_take = access & apb_i.pwrite & hit;

  assign enables = {regs_reg.en_hi, regs_reg.en_lo};
  assign staged  = {regs_reg.stg_hi, regs_reg.stg_lo};

  // The compare match inputs come from the timer on this clock, so no synchroniser.
  for (genvar g = 0; g < GROUPS; g++) begin : g_group
    assign fire[g] = cmp_match_i[regs_reg.trig[SEL_W*g +: SEL_W]];
    assign copy_mask[GROUP_W*g +: GROUP_W] = enables[GROUP_W*g +: GROUP_W] &
                                             {GROUP_W{fire[g]}};
  end

  always_comb begin
    regs_next       = regs_reg;
    // Software writes reach only disabled bits, so they never collide with the copy.
    regs_next.latch = (regs_reg.latch & ~copy_mask) | (staged & copy_mask);
    if (wr_take) begin
      if (!ofs[0] && apb_i.pstrb[1]) begin
        regs_next = put_byte(regs_next, ofs, apb_i.pwdata[15:8]);
      end
      if (apb_i.pstrb[0]) begin
        regs_next = put_byte(regs_next, ofs[0] ? ofs : ofs_odd, apb_i.pwdata[7:0]);
      end
    end
  end

  // Only reset clears state; a standby request has no path into these flops.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      regs_reg <= REGS_RST;
    end else begin
      regs_reg <= regs_next;
    end
  end

  always_comb begin
    rd_word = RST_WORD;
    if (hit) begin
      if (ofs[0]) begin
        rd_word[7:0] = get_byte(regs_reg, ofs);
      end else begin
        rd_word[15:0] = {get_byte(regs_reg, ofs), get_byte(regs_reg, ofs_odd)};
      end
    end
    prdata_next = setup ? rd_word : prdata_reg;
  end

  // Read data is sampled in the setup cycle; a trigger in the access cycle is not seen.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prdata_reg <= RST_WORD;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign apb_o.prdata       = prdata_reg;
  assign apb_o.pready       = 1'b1;
  assign apb_o.pslverr      = access & ~hit;
  assign pattern_out_pins_o = regs_reg.latch;
  assign pin_function_o     = {regs_reg.func_hi, regs_reg.func_lo};
  assign pattern_mode_o     = regs_reg.mode;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_copy_group0;
    (fire[0] && regs_reg.en_lo[0]) |=> (pattern_out_pins_o[0] == $past(regs_reg.stg_lo[0]));
  endproperty
  a_copy_group0: assert property (p_copy_group0) else $error("Group 0 copy missed.");

  property p_sel_ch1;
    (regs_reg.trig[SEL_W-1:0] == 2'b01 && cmp_match_i[1] && regs_reg.en_lo[1])
      |=> (pattern_out_pins_o[1] == $past(regs_reg.stg_lo[1]));
  endproperty
  a_sel_ch1: assert property (p_sel_ch1) else $error("Channel 1 select failed.");

  property p_disabled_hold;
    (!regs_reg.en_hi[7] && !wr_take) |=> $stable(pattern_out_pins_o[15]);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("Disabled pin changed.");

  property p_locked_bit;
    (wr_take && ofs[OFS_HI:1] == IDX_LATCH[OFS_HI:1] && apb_i.pstrb[0] && regs_reg.en_lo[2] && !fire[0])
      |=> $stable(pattern_out_pins_o[2]);
  endproperty
  a_locked_bit: assert property (p_locked_bit) else $error("Enabled latch bit was written.");

  property p_alt_ones;
    (setup && hit && ofs[OFS_HI:1] == IDX_STG_LO_ALT[OFS_HI:1] && same_lo(regs_reg))
      |=> (apb_o.prdata[7:0] == RSVD_BYTE);
  endproperty
  a_alt_ones: assert property (p_alt_ones) else $error("Reserved byte not all ones.");

  property p_split_nibble;
    (setup && hit && ofs[OFS_HI:1] == IDX_STG_LO[OFS_HI:1] && !same_lo(regs_reg))
      |=> (apb_o.prdata[3:0] == RSVD_NIB);
  endproperty
  a_split_nibble: assert property (p_split_nibble) else $error("Unused nibble not ones.");

  property p_split_write;
    (wr_take && ofs[OFS_HI:1] == IDX_STG_LO_ALT[OFS_HI:1] && apb_i.pstrb[0] && !same_lo(regs_reg))
      |=> $stable(regs_reg.stg_lo[7:4]);
  endproperty
  a_split_write: assert property (p_split_write) else $error("Alternate write hit group 1.");

  property p_shared_write;
    (wr_take && ofs[OFS_HI:1] == IDX_STG_LO[OFS_HI:1] && same_lo(regs_reg) && apb_i.pstrb[0])
      |=> (regs_reg.stg_lo == $past(apb_i.pwdata[7:0]));
  endproperty
  a_shared_write: assert property (p_shared_write) else $error("Shared byte write lost.");

  property p_area_decode;
    disable iff (!rst_n_i)
    (access && apb_i.paddr[1:0] == 2'b00 && idx[AREA_HI:AREA_LO] == IDX_TRIG[AREA_HI:AREA_LO]
      && ofs == IDX_TRIG[OFS_HI:0]) |-> !apb_o.pslverr;
  endproperty
  a_area_decode: assert property (p_area_decode) else $error("Aliased address refused.");

  property p_reset_clear;
    disable iff (1'b0)
    !rst_n_i |=> (pattern_out_pins_o == RST_HALF && regs_reg.stg_lo == RST_BYTE);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Reset did not clear.");

  property p_copy_group1;
    (fire[1] && regs_reg.en_lo[4]) |=> (pattern_out_pins_o[4] == $past(regs_reg.stg_lo[4]));
  endproperty
  a_copy_group1: assert property (p_copy_group1) else $error("Group 1 copy missed.");

  property p_copy_group2;
    (fire[2] && regs_reg.en_hi[0]) |=> (pattern_out_pins_o[8] == $past(regs_reg.stg_hi[0]));
  endproperty
  a_copy_group2: assert property (p_copy_group2) else $error("Group 2 copy missed.");

  property p_copy_group3;
    (fire[3] && regs_reg.en_hi[7]) |=> (pattern_out_pins_o[15] == $past(regs_reg.stg_hi[7]));
  endproperty
  a_copy_group3: assert property (p_copy_group3) else $error("Group 3 copy missed.");

  property p_sel_ch0;
    (regs_reg.trig[4*SEL_W-1:3*SEL_W] == 2'b00 && cmp_match_i[0] && regs_reg.en_hi[6])
      |=> (pattern_out_pins_o[14] == $past(regs_reg.stg_hi[6]));
  endproperty
  a_sel_ch0: assert property (p_sel_ch0) else $error("Channel 0 select failed.");

  property p_sel_ch2;
    (regs_reg.trig[2*SEL_W-1:SEL_W] == 2'b10 && cmp_match_i[2] && regs_reg.en_lo[7])
      |=> (pattern_out_pins_o[7] == $past(regs_reg.stg_lo[7]));
  endproperty
  a_sel_ch2: assert property (p_sel_ch2) else $error("Channel 2 select failed.");

  property p_no_match_hold;
    (cmp_match_i == '0 && !wr_take) |=> $stable(pattern_out_pins_o);
  endproperty
  a_no_match_hold: assert property (p_no_match_hold) else $error("Pins moved without a trigger.");

  property p_group_isolation;
    (!fire[1] && !wr_take) |=> $stable(pattern_out_pins_o[7:4]);
  endproperty
  a_group_isolation: assert property (p_group_isolation) else $error("Group 1 moved on another trigger.");

  property p_locked_high;
    (wr_take && ofs == IDX_LATCH[OFS_HI:0] && apb_i.pstrb[1] && !fire[2] && !fire[3])
      |=> ((pattern_out_pins_o[15:8] & $past(regs_reg.en_hi)) ==
           ($past(pattern_out_pins_o[15:8]) & $past(regs_reg.en_hi)));
  endproperty
  a_locked_high: assert property (p_locked_high) else $error("Enabled high latch bits were written.");

  property p_free_write;
    (wr_take && ofs == IDX_LATCH[OFS_HI:0] && apb_i.pstrb[0])
      |=> ((pattern_out_pins_o[7:0] & ~$past(regs_reg.en_lo)) ==
           ($past(apb_i.pwdata[7:0]) & ~$past(regs_reg.en_lo)));
  endproperty
  a_free_write: assert property (p_free_write) else $error("Writable latch bits lost a write.");

  property p_func_hi_write;
    (wr_take && ofs == IDX_FUNC_HI[OFS_HI:0] && apb_i.pstrb[1])
      |=> (pin_function_o[31:24] == $past(apb_i.pwdata[15:8]));
  endproperty
  a_func_hi_write: assert property (p_func_hi_write) else $error("Function high write lost.");

  property p_func_lo_write;
    (wr_take && ofs == IDX_FUNC_LO[OFS_HI:0] && apb_i.pstrb[0])
      |=> (pin_function_o[7:0] == $past(apb_i.pwdata[7:0]));
  endproperty
  a_func_lo_write: assert property (p_func_lo_write) else $error("Function low write lost.");

  property p_alias_hi;
    (setup && hit && ofs == IDX_STG_HI_ALT[OFS_HI:0] && same_hi(regs_reg))
      |=> (apb_o.prdata[15:8] == RSVD_BYTE);
  endproperty
  a_alias_hi: assert property (p_alias_hi) else $error("High reserved byte not all ones.");

  property p_split_hi_nibble;
    (setup && hit && ofs == IDX_STG_HI[OFS_HI:0] && !same_hi(regs_reg))
      |=> (apb_o.prdata[11:8] == RSVD_NIB);
  endproperty
  a_split_hi_nibble: assert property (p_split_hi_nibble) else $error("High unused nibble not ones.");

  property p_split_lo_alt_nibble;
    (setup && hit && ofs[OFS_HI:1] == IDX_STG_LO_ALT[OFS_HI:1] && !same_lo(regs_reg))
      |=> (apb_o.prdata[7:4] == RSVD_NIB);
  endproperty
  a_split_lo_alt_nibble: assert property (p_split_lo_alt_nibble) else $error("Alternate nibble not ones.");

  property p_shared_hi_write;
    (wr_take && ofs == IDX_STG_HI[OFS_HI:0] && same_hi(regs_reg) && apb_i.pstrb[1])
      |=> (regs_reg.stg_hi == $past(apb_i.pwdata[15:8]));
  endproperty
  a_shared_hi_write: assert property (p_shared_hi_write) else $error("Shared high byte write lost.");

  property p_split_hi_write;
    (wr_take && ofs == IDX_STG_HI_ALT[OFS_HI:0] && !same_hi(regs_reg) && apb_i.pstrb[1])
      |=> (regs_reg.stg_hi[3:0] == $past(apb_i.pwdata[11:8]) && $stable(regs_reg.stg_hi[7:4]));
  endproperty
  a_split_hi_write: assert property (p_split_hi_write) else $error("Group 2 alternate write wrong.");

  property p_alt_drop;
    (wr_take && ofs[OFS_HI:1] == IDX_STG_LO_ALT[OFS_HI:1] && apb_i.pstrb[0] && same_lo(regs_reg))
      |=> $stable(regs_reg.stg_lo);
  endproperty
  a_alt_drop: assert property (p_alt_drop) else $error("Reserved byte write was taken.");

  property p_read_halfword;
    (setup && hit && ofs == IDX_LATCH[OFS_HI:0])
      |=> (apb_o.prdata[15:0] == $past(pattern_out_pins_o));
  endproperty
  a_read_halfword: assert property (p_read_halfword) else $error("Latch halfword read wrong.");

  property p_odd_read;
    (setup && hit && ofs[0]) |=> (apb_o.prdata[31:8] == '0);
  endproperty
  a_odd_read: assert property (p_odd_read) else $error("Odd byte read spilled upward.");

  property p_reset_regs;
    disable iff (1'b0)
    !rst_n_i |=> (pin_function_o == '0 && pattern_mode_o == RST_MODE &&
                  regs_reg.trig == RST_TRIG && regs_reg.en_lo == RST_BYTE);
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("Reset left a register set.");

endmodule : timed_pattern_unit

// ### src/pattern_pkg.sv
package pattern_pkg;

  // Register indices; byte address on the bus is four times the index.
  localparam logic [27:0] IDX_LATCH       = 28'h5ffffc2;
  localparam logic [27:0] IDX_FUNC_HI     = 28'h5ffffcc;
  localparam logic [27:0] IDX_FUNC_LO     = 28'h5ffffce;
  localparam logic [27:0] IDX_MODE        = 28'h5fffff0;
  localparam logic [27:0] IDX_TRIG        = 28'h5fffff1;
  localparam logic [27:0] IDX_EN_HI       = 28'h5fffff2;
  localparam logic [27:0] IDX_EN_LO       = 28'h5fffff3;
  localparam logic [27:0] IDX_STG_HI      = 28'h5fffff4;
  localparam logic [27:0] IDX_STG_LO      = 28'h5fffff5;
  localparam logic [27:0] IDX_STG_HI_ALT  = 28'h5fffff6;
  localparam logic [27:0] IDX_STG_LO_ALT  = 28'h5fffff7;

  localparam int          AREA_HI         = 27;
  localparam int          AREA_LO         = 24;
  localparam int          OFS_HI          = 8;
  localparam int          WORD_LSB        = 2;

  localparam int          GROUPS          = 4;
  localparam int          GROUP_W         = 4;
  localparam int          SEL_W           = 2;
  localparam int          PINS            = 16;

  localparam logic [7:0]  RST_MODE        = 8'hf0;
  localparam logic [7:0]  RST_TRIG        = 8'hff;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_HALF        = 16'h0000;
  localparam logic [7:0]  RSVD_BYTE       = 8'hff;
  localparam logic [3:0]  RSVD_NIB        = 4'hf;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;

  typedef struct packed {
    logic [15:0] latch;
    logic [15:0] func_hi;
    logic [15:0] func_lo;
    logic [7:0]  mode;
    logic [7:0]  trig;
    logic [7:0]  en_hi;
    logic [7:0]  en_lo;
    logic [7:0]  stg_hi;
    logic [7:0]  stg_lo;
  } regs_t;

  localparam regs_t REGS_RST = '{RST_HALF, RST_HALF, RST_HALF, RST_MODE, RST_TRIG,
                                 RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE};

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage : pattern_pkg

// ### testbench/pattern_load.sv
`timescale 1ns/1ps
// Loads on the pattern pins; a pin not given the pattern function is undriven here and its pull-down wins.
module pattern_load (
  input  wire logic [15:0] pins_i,
  input  wire logic [31:0] function_i,
  output      logic [15:0] seen_o
);
  always_comb begin
    for (int i = 0; i < 16; i++) seen_o[i] = (function_i[2*i+:2] == 2'b11) ? pins_i[i] : 1'b0;
  end
endmodule : pattern_load

// ### testbench/test_timed_pattern_unit.sv
`timescale 1ns/1ps
module test_timed_pattern_unit;
  import pattern_pkg::*;
  logic        mclk_i      = 1'b0;
  logic        rst_n_i     = 1'b0;
  apb_req_t    req         = '0;
  apb_rsp_t    rsp;
  logic [3:0]  cmp         = 4'h0;
  logic [15:0] pins;
  logic [15:0] seen;
  logic [31:0] fn;
  logic [7:0]  mode;
  logic [31:0] seed        = 32'h5863;
  logic [31:0] fn_exp;
  logic [31:0] r;
  logic [31:0] r2;
  logic [31:0] r3;
  logic [31:0] rd;
  logic        er;
  logic [15:0] lat;
  logic [15:0] stg;
  logic [15:0] en;
  logic [7:0]  trg;
  int          err_total   = 0;
  int          checks_done = 0;

  always #2 mclk_i = ~mclk_i;

  timed_pattern_unit timed_pattern_unit_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp),
    .cmp_match_i(cmp), .pattern_out_pins_o(pins), .pin_function_o(fn), .pattern_mode_o(mode));
  pattern_load pattern_load_inst (.pins_i(pins), .function_i(fn), .seen_o(seen));

  function logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    return seed;
  endfunction : rnd

  function automatic logic sh(input logic hi);
    return hi ? (trg[7:6] == trg[5:4]) : (trg[3:2] == trg[1:0]);
  endfunction : sh

  // Expected byte at a staging address; a split pair shows ones in the unused nibble.
  function automatic logic [7:0] stg_byte(input logic hi, input logic alt);
    logic [7:0] d;
    d = hi ? stg[15:8] : stg[7:0];
    if (sh(hi)) return alt ? 8'hff : d;
    return alt ? {4'hf, d[3:0]} : {d[7:4], 4'hf};
  endfunction : stg_byte

  function automatic logic [15:0] load_view();
    logic [15:0] v;
    for (int i = 0; i < PINS; i++) v[i] = (fn_exp[2*i+:2] == 2'b11) & lat[i];
    return v;
  endfunction : load_view

  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Entered just after a rising edge; holds the request until pready is seen at an edge.
  task automatic bus(input logic wr, input logic [27:0] idx, input logic [15:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, {16'h0000, wd}, st};
    @(posedge mclk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    rd = rsp.prdata;
    er = rsp.pslverr;
    if (rsp.pready !== 1'b1) check(33'h0, 33'h1, "bus wait");
    req <= '0;
    @(posedge mclk_i);
  endtask : bus

  task automatic rd_chk(input logic [27:0] idx, input logic [15:0] exp, input logic [15:0] m, input string what);
    bus(1'b0, idx, 16'h0000, 4'h0);
    check({16'h0000, er, rd[15:0] & m}, {17'h00000, exp}, what);
  endtask : rd_chk

  task automatic pulse(input logic [3:0] v);
    cmp <= v;
    for (int g = 0; g < GROUPS; g++)
      if (v[trg[2*g+:2]]) lat[4*g+:4] = (lat[4*g+:4] & ~en[4*g+:4]) | (stg[4*g+:4] & en[4*g+:4]);
    @(posedge mclk_i);
    cmp <= 4'h0;
    @(negedge mclk_i);
    check({17'h0, pins}, {17'h0, lat}, "pins after trigger");
    check({17'h0, seen}, {17'h0, load_view()}, "load view");
    @(posedge mclk_i);
  endtask : pulse

  initial begin
    #40000;
    check(33'h0, 33'h1, "watchdog");
    print_verdict();
  end

  initial begin
    fn_exp = '0;
    lat = '0;
    stg = '0;
    en = '0;
    trg = RST_TRIG;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    check({9'h0, mode, pins}, {9'h0, RST_MODE, 16'h0000}, "reset outputs");
    check({1'b0, fn}, 33'h0, "reset function");
    rd_chk(IDX_LATCH, 16'h0000, 16'hffff, "latch reset");
    rd_chk(IDX_MODE, {RST_MODE, RST_TRIG}, 16'hffff, "mode reset");
    rd_chk(IDX_STG_HI, 16'h0000, 16'hffff, "staging reset");
    rd_chk(IDX_STG_HI_ALT, 16'hffff, 16'hffff, "alt reset");
    rd_chk(IDX_TRIG, {8'h00, RST_TRIG}, 16'h00ff, "odd byte read");
    bus(1'b0, 28'h5ffffd0, 16'h0000, 4'h0);
    check({er, rd}, {1'b1, 32'h0}, "unmapped");
    for (int it = 0; it < 40; it++) begin
      r = rnd();
      r2 = rnd();
      r3 = rnd();
      fn_exp = (it % 2) ? 32'hffff_ffff : r;
      bus(1'b1, IDX_FUNC_HI, fn_exp[31:16], 4'h3);
      bus(1'b1, IDX_FUNC_LO, fn_exp[15:0], 4'h3);
      check({1'b0, fn}, {1'b0, fn_exp}, "function regs");
      trg = r2[7:0];
      if (it % 3 == 0) trg = {{2{trg[7:6]}}, {2{trg[3:2]}}};
      bus(1'b1, IDX_MODE, {r2[15:8], trg}, 4'h3);
      rd_chk(IDX_MODE, {r2[15:8], trg}, 16'hffff, "trigger select");
      check({25'h0, mode}, {25'h0, r2[15:8]}, "mode output");
      en = r2[31:16];
      bus(1'b1, IDX_EN_HI, {en[15:8], 8'h00}, 4'h2);
      bus(1'b1, IDX_EN_LO, {8'h00, en[7:0]}, 4'h1);
      rd_chk(IDX_EN_HI, en, 16'hffff, "enables");
      stg = r3[15:0];
      bus(1'b1, IDX_STG_HI, {stg_byte(1'b1, 1'b0), stg_byte(1'b0, 1'b0)}, 4'h3);
      // Shared pairs get junk at the alternate address; it must be dropped.
      bus(1'b1, IDX_STG_HI_ALT, {stg_byte(1'b1, 1'b1) ^ (sh(1'b1) ? r3[31:24] : 8'h00),
                                 stg_byte(1'b0, 1'b1) ^ (sh(1'b0) ? r3[23:16] : 8'h00)}, 4'h3);
      rd_chk(IDX_STG_HI, {stg_byte(1'b1, 1'b0), stg_byte(1'b0, 1'b0)}, 16'hffff, "staging");
      rd_chk(IDX_STG_HI_ALT, {stg_byte(1'b1, 1'b1), stg_byte(1'b0, 1'b1)}, 16'hffff, "alt staging");
      lat = (lat & en) | (r3[31:16] & ~en);
      bus(1'b1, IDX_LATCH ^ (r[27:0] & 28'h0fffe00), r3[31:16], 4'h3);
      rd_chk(IDX_LATCH, lat, 16'hffff, "latch write");
      pulse(r[3:0]);
      pulse(4'hf);
      rd_chk(IDX_LATCH + 28'h1, {8'h00, lat[7:0]}, 16'h00ff, "latch low byte");
    end
    print_verdict();
  end
endmodule : test_timed_pattern_unit
